// ### core/mios_status.sv
// Summary of operation
// - a read-only 16-bit word shows which inputs and the ready output (bit 15) are active.
// - bits 2..6 show axis A/B, auxiliary A/B and the auxiliary index inputs.
// - bits 7..11 show marker, home, forward and reverse overtravel, and enable.
// - bit 12 follows the present capture input level.
// - bit 13 sets on a capture rising edge and holds until a position-capture reset.
// - with computer format enabled a word query returns the value, zero when nothing is active.
// - a query naming bit 0..15 returns only that bit's state.
`timescale 1ns/1ns
`default_nettype none
module mios_status (
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          clk_en,
   input  wire logic                          axis_a,
   input  wire logic                          axis_b,
   input  wire logic                          aux_a,
   input  wire logic                          aux_b,
   input  wire logic                          aux_index,
   input  wire logic                          marker,
   input  wire logic                          home,
   input  wire logic                          fwd_overtravel,
   input  wire logic                          rev_overtravel,
   input  wire logic                          enable_in,
   input  wire logic                          capture_in,
   input  wire logic                          ready_out,
   input  wire logic                          position_capture,
   input  wire logic                          computer_format_enable,
   input  wire logic                          query_req,
   input  wire logic                          query_bit,
   input  wire logic [3:0]                    query_index,
   output logic      [mios_pkg::STATUS_W-1:0] input_output_status,
   output logic                               query_valid,
   output var mios_pkg::mios_query_t          query_kind,
   output logic      [mios_pkg::STATUS_W-1:0] query_data
);
   import mios_pkg::*;

   logic [NUM_PINS-1:0] pins_raw;
   logic [NUM_PINS-1:0] pins_sync;
   logic                cap_prev;
   logic                cap_edge;
   logic [STATUS_W-1:0] next_status;

   assign pins_raw = {capture_in, enable_in, rev_overtravel, fwd_overtravel, home,
                      marker, aux_index, aux_b, aux_a, axis_b, axis_a};

   mios_sync u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   // ========================================
   // capture edge latch
   // edge taken after the synchroniser so a metastable pin cannot fake one
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_prev <= 1'b0;
      end else if (clk_en) begin
         cap_prev <= pins_sync[NUM_PINS-1];
      end
   end

   // edge wins over a coincident reset so no capture is lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_edge <= 1'b0;
      end else if (clk_en) begin
         if (pins_sync[NUM_PINS-1] && !cap_prev) begin
            cap_edge <= 1'b1;
         end else if (position_capture) begin
            cap_edge <= 1'b0;
         end
      end
   end

   // ========================================
   // status word
   always_comb begin
      next_status               = STATUS_RESET;
      next_status[BIT_AXIS_A]   = pins_sync[0];
      next_status[BIT_AXIS_B]   = pins_sync[1];
      next_status[BIT_AUX_A]    = pins_sync[2];
      next_status[BIT_AUX_B]    = pins_sync[3];
      next_status[BIT_AUX_IDX]  = pins_sync[4];
      next_status[BIT_MARKER]   = pins_sync[5];
      next_status[BIT_HOME]     = pins_sync[6];
      next_status[BIT_FWD_OT]   = pins_sync[7];
      next_status[BIT_REV_OT]   = pins_sync[8];
      next_status[BIT_ENABLE]   = pins_sync[9];
      next_status[BIT_CAP_LVL]  = pins_sync[10];
      next_status[BIT_CAP_EDGE] = cap_edge;
      // ready is same-domain logic, no synchroniser
      next_status[BIT_READY]    = ready_out;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         input_output_status <= STATUS_RESET;
      end else if (clk_en) begin
         input_output_status <= next_status & ~RSVD_MASK;
      end
   end

   // ========================================
   // query answers, one cycle after request
   // bit query reads the word as registered, not the raw pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         query_valid <= 1'b0;
         query_kind  <= MIOS_Q_WORD;
         query_data  <= STATUS_RESET;
      end else if (clk_en) begin
         query_valid <= query_req;
         if (query_req) begin
            if (query_bit) begin
               query_kind <= MIOS_Q_BIT;
               query_data <= {15'h0000, input_output_status[query_index]};
            end else if (computer_format_enable) begin
               query_kind <= MIOS_Q_WORD;
               query_data <= input_output_status;
            end else begin
               // text rendering is left to firmware; word still given
               query_kind <= MIOS_Q_TEXT;
               query_data <= input_output_status;
            end
         end
      end
   end

   // ========================================
   // checks: word layout
   a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (input_output_status & RSVD_MASK) == 16'h0000)
      else $error("reserved status bit set");
   a_idle_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && pins_sync == '0 && !cap_edge && !ready_out) |=> input_output_status == 16'h0000)
      else $error("idle word not zero");
   a_ready_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_READY] == $past(ready_out))
      else $error("ready bit wrong");
   a_status_frozen: assert property (@(posedge clk) disable iff (!rst_b)
      !clk_en |=> $stable(input_output_status))
      else $error("status moved while disabled");
   a_axis_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_AXIS_A] == $past(pins_sync[0]))
      else $error("axis A bit wrong");
   a_axis_b_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_AXIS_B] == $past(pins_sync[1]))
      else $error("axis B bit wrong");
   a_aux_a_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_AUX_A] == $past(pins_sync[2]))
      else $error("aux A bit wrong");
   a_aux_b_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_AUX_B] == $past(pins_sync[3]))
      else $error("aux B bit wrong");
   a_index_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_AUX_IDX] == $past(pins_sync[4]))
      else $error("aux index bit wrong");
   a_marker_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_MARKER] == $past(pins_sync[5]))
      else $error("marker bit wrong");
   a_home_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_HOME] == $past(pins_sync[6]))
      else $error("home bit wrong");
   a_fwd_ot_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_FWD_OT] == $past(pins_sync[7]))
      else $error("forward overtravel bit wrong");
   a_rev_ot_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_REV_OT] == $past(pins_sync[8]))
      else $error("reverse overtravel bit wrong");
   a_enable_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_ENABLE] == $past(pins_sync[9]))
      else $error("enable bit wrong");

   // ========================================
   // checks: capture
   a_cap_level: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_CAP_LVL] == $past(pins_sync[NUM_PINS-1]))
      else $error("capture level bit wrong");
   a_edge_sets: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && pins_sync[NUM_PINS-1] && !cap_prev) |=> cap_edge)
      else $error("capture edge not latched");
   a_edge_holds: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && cap_edge && !position_capture) |=> cap_edge)
      else $error("capture edge flag dropped without reset");
   a_edge_clears: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && position_capture && !(pins_sync[NUM_PINS-1] && !cap_prev)) |=> !cap_edge)
      else $error("capture edge flag not cleared");
   a_edge_bit: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en |=> input_output_status[BIT_CAP_EDGE] == $past(cap_edge))
      else $error("capture edge bit wrong");

   // ========================================
   // checks: queries
   a_word_query: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && query_req && !query_bit && computer_format_enable)
      |=> query_valid && query_kind == MIOS_Q_WORD
          && query_data == $past(input_output_status))
      else $error("word query answer wrong");
   a_text_kind: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && query_req && !query_bit && !computer_format_enable)
      |=> query_kind == MIOS_Q_TEXT && query_data == $past(input_output_status))
      else $error("text query answer wrong");
   a_bit_query: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && query_req && query_bit)
      |=> query_data[15:1] == 15'h0000 && query_kind == MIOS_Q_BIT)
      else $error("bit query answer wrong");
   a_bit_value: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && query_req && query_bit)
      |=> query_data[0] == $past(input_output_status[query_index]))
      else $error("bit query value wrong");
   a_query_answer: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && query_req) |=> query_valid)
      else $error("query not answered");
   a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && !query_req) |=> !query_valid)
      else $error("answer strobe without request");
   a_query_frozen: assert property (@(posedge clk) disable iff (!rst_b)
      !clk_en |=> $stable(query_valid) && $stable(query_data))
      else $error("answer moved while disabled");
endmodule
`default_nettype wire

// ### shared/mios_pkg.sv
`default_nettype none
package mios_pkg;
   // ========================================
   // status word layout
   localparam int          STATUS_W     = 16;
   localparam int          BIT_AXIS_A   = 2;
   localparam int          BIT_AXIS_B   = 3;
   localparam int          BIT_AUX_A    = 4;
   localparam int          BIT_AUX_B    = 5;
   localparam int          BIT_AUX_IDX  = 6;
   localparam int          BIT_MARKER   = 7;
   localparam int          BIT_HOME     = 8;
   localparam int          BIT_FWD_OT   = 9;
   localparam int          BIT_REV_OT   = 10;
   localparam int          BIT_ENABLE   = 11;
   localparam int          BIT_CAP_LVL  = 12;
   localparam int          BIT_CAP_EDGE = 13;
   localparam int          BIT_READY    = 15;
   localparam int          NUM_PINS     = 11;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] RSVD_MASK    = 16'h4003;
   localparam logic [3:0]  BIT_SEL_MAX  = 4'hF;
   // ========================================
   // query kinds
   typedef enum logic [1:0] {
      MIOS_Q_WORD,
      MIOS_Q_BIT,
      MIOS_Q_TEXT
   } mios_query_t;
endpackage
`default_nettype wire

// ### core/mios_sync.sv
`timescale 1ns/1ns
`default_nettype none
module mios_sync (
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          clk_en,
   input  wire logic [mios_pkg::NUM_PINS-1:0] async_in,
   output logic      [mios_pkg::NUM_PINS-1:0] sync_out
);
   import mios_pkg::*;

   logic [NUM_PINS-1:0] stage1;

   // ========================================
   // two-flop synchroniser per pin
   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++) begin : g_sync
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               stage1[i]   <= 1'b0;
               sync_out[i] <= 1'b0;
            end else if (clk_en) begin
               stage1[i]   <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### tb/mios_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// switch, encoder and sensor bank
module mios_pins_model (
   input  wire logic [10:0] level,
   output logic      [10:0] pins
);
   // clean levels only: no contact bounce, so pin glitch filtering is not exercised
   assign pins = level;
endmodule
`default_nettype wire

// ### tb/mios_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mios_status_tb;
   import mios_pkg::*;
   // ========================================
   // stimulus and observation
   logic        clk       = 1'b0;
   logic        rst_b;
   logic        clk_en    = 1'b1;
   logic [10:0] level;
   logic [10:0] pins;
   logic        ready_out;
   logic        pc        = 1'b0;
   logic        cfe       = 1'b1;
   logic        qreq      = 1'b0;
   logic        qbit      = 1'b0;
   logic [3:0]  qidx      = 4'h0;
   logic [15:0] st;
   logic [15:0] qdata;
   logic        qvalid;
   mios_query_t qkind;
   int          err_count = 0;
   int          checked   = 0;
   always #5 clk = ~clk;
   mios_pins_model u_mios_pins_model (.level(level), .pins(pins));
   mios_status u_mios_status (
      .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .axis_a(pins[0]), .axis_b(pins[1]),
      .aux_a(pins[2]), .aux_b(pins[3]), .aux_index(pins[4]), .marker(pins[5]),
      .home(pins[6]), .fwd_overtravel(pins[7]), .rev_overtravel(pins[8]),
      .enable_in(pins[9]), .capture_in(pins[10]), .ready_out(ready_out),
      .position_capture(pc), .computer_format_enable(cfe), .query_req(qreq),
      .query_bit(qbit), .query_index(qidx), .input_output_status(st),
      .query_valid(qvalid), .query_kind(qkind), .query_data(qdata));
   // ========================================
   // shared tasks
   task results;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task chk_kind(input mios_query_t got, input mios_query_t exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task chk_flag(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task clear_capture;
      pc = 1'b1;
      settle(1);
      pc = 1'b0;
      settle(3);
   endtask
   // answer is polled with a bound so a dead query port cannot hang the run
   task query(input logic b, input logic [3:0] idx);
      int n;
      n = 0;
      // one idle edge keeps back-to-back calls from lowering and raising in one step
      settle(1);
      qreq = 1'b1;
      qbit = b;
      qidx = idx;
      settle(1);
      qreq = 1'b0;
      while (qvalid !== 1'b1 && n < 4) begin
         settle(1);
         n++;
      end
      if (qvalid !== 1'b1) begin
         err_count++;
         $display("MISMATCH at %0t: query not answered", $time);
         results();
      end
   endtask
   // ========================================
   // scenarios
   task t_pins;
      logic [15:0] exp;
      for (int i = 0; i < 11; i++) begin
         level = 11'h001 << i;
         settle(5);
         exp = (16'h0004 << i) | ((i == 10) ? 16'h2000 : 16'h0000);
         chk(st, exp, "single pin");
      end
      level = 11'h000;
      clear_capture();
      chk(st, 16'h0000, "all idle");
      ready_out = 1'b1;
      settle(3);
      chk(st, 16'h8000, "ready bit");
      ready_out = 1'b0;
      settle(3);
      $display("test pins done");
   endtask
   task t_capture;
      level[10] = 1'b1;
      settle(5);
      chk(st, 16'h3000, "capture high");
      level[10] = 1'b0;
      settle(5);
      chk(st, 16'h2000, "edge sticky");
      clear_capture();
      chk(st, 16'h0000, "edge cleared");
      $display("test capture done");
   endtask
   task t_query;
      level = 11'h7FF;
      ready_out = 1'b1;
      settle(6);
      chk(st, 16'hBFFC, "all active");
      query(1'b0, 4'h0);
      chk(qdata, 16'hBFFC, "word value");
      chk_kind(qkind, MIOS_Q_WORD, "word kind");
      settle(1);
      chk_flag(qvalid, 1'b0, "valid one cycle");
      cfe = 1'b0;
      query(1'b0, 4'h0);
      chk_kind(qkind, MIOS_Q_TEXT, "text kind");
      chk(qdata, 16'hBFFC, "text word");
      cfe = 1'b1;
      for (int i = 0; i < 16; i++) begin
         query(1'b1, i[3:0]);
         chk(qdata, (16'hBFFC >> i) & 16'h0001, "bit value");
         chk_kind(qkind, MIOS_Q_BIT, "bit kind");
      end
      $display("test query done");
   endtask
   task t_reset(input int n);
      rst_b     = 1'b0;
      level     = 11'h000;
      ready_out = 1'b0;
      settle(n);
      chk(st, 16'h0000, "status in reset");
      chk(qdata, 16'h0000, "data in reset");
      chk_kind(qkind, MIOS_Q_WORD, "kind in reset");
      chk_flag(qvalid, 1'b0, "valid in reset");
      rst_b = 1'b1;
      settle(2);
      chk(st, 16'h0000, "idle after release");
      $display("test reset done");
   endtask
   task t_freeze;
      clk_en   = 1'b0;
      level[6] = 1'b1;
      settle(5);
      chk(st, 16'h0000, "frozen word");
      qreq = 1'b1;
      settle(1);
      qreq   = 1'b0;
      clk_en = 1'b1;
      chk_flag(qvalid, 1'b0, "frozen query");
      settle(5);
      chk(st, 16'h0100, "home after thaw");
      chk_flag(qvalid, 1'b0, "request ignored");
      level[6] = 1'b0;
      settle(5);
      $display("test freeze done");
   endtask
   initial begin
      t_reset(10);
      t_pins();
      t_capture();
      t_freeze();
      t_query();
      t_reset(3);
      results();
   end
endmodule
`default_nettype wire
